// ### sssb_consts.vh
`ifndef SSSB_CONSTS_VH
`define SSSB_CONSTS_VH
// register offsets
`define SSSB_ADDR_W          4
`define SSSB_REG_CTRL        4'h0
`define SSSB_REG_STATUS      4'h1
`define SSSB_REG_IRQ_STAT    4'h2
`define SSSB_REG_IRQ_MASK    4'h3
`define SSSB_REG_LANES       4'h4
// control bits
`define SSSB_CTRL_W          8
`define SSSB_CTRL_RESET      8'h00
`define SSSB_CTRL_SATA       0
`define SSSB_CTRL_WAKE       1
`define SSSB_CTRL_CLKREQ     2
`define SSSB_CTRL_LED        3
`define SSSB_CTRL_ALERT      4
`define SSSB_CTRL_ACT        5
`define SSSB_CTRL_SMB_EN     6
// event bits
`define SSSB_EV_W            6
`define SSSB_EV_ZERO         6'h00
`define SSSB_EV_PERST_ON     0
`define SSSB_EV_PERST_OFF    1
`define SSSB_EV_SLP_ON       2
`define SSSB_EV_SLP_OFF      3
`define SSSB_EV_OBFF         4
`define SSSB_EV_CLKREQ       5
// lane count
`define SSSB_MAX_LANES       3'h4
`define SSSB_MIN_LANES       3'h2
// suspend clock: 32.768 kHz, duty 30..70 percent
`define SSSB_MCLK_HZ         50000000
`define SSSB_SUS_HZ          32768
`define SSSB_SUS_DUTY_MIN    30
`define SSSB_SUS_DUTY_MAX    70
`define SSSB_CNT_W           12
`define SSSB_SUS_TICK_MAX    12'h5FA
`endif

// ### sssb_sync.v
`timescale 1ns/1ps
module sssb_sync (
   mclk,
   rst,
   din,
   dout
);
   parameter RST_VAL = 1'b1;
   input  wire mclk;
   input  wire rst;
   input  wire din;
   output reg  dout;
   reg         stage1;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stage1 <= RST_VAL;
         dout   <= RST_VAL;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // sssb_sync

// ### sssb_suspend_clock_mon.v
`timescale 1ns/1ps
`include "sssb_consts.vh"
module sssb_suspend_clock_mon (
   mclk,
   rst,
   sus_sync,
   sus_rise,
   sus_alive
);
   input  wire mclk;
   input  wire rst;
   input  wire sus_sync;
   output reg  sus_rise;
   output reg  sus_alive;
   reg                    sus_q;
   reg [`SSSB_CNT_W-1:0]  gap;
   // edge based only, so any duty between the limits is accepted
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sus_q     <= 1'b0;
         sus_rise  <= 1'b0;
         sus_alive <= 1'b0;
         gap       <= {`SSSB_CNT_W{1'b0}};
      end else begin
         sus_q    <= sus_sync;
         sus_rise <= sus_sync & ~sus_q;
         if (sus_sync & ~sus_q) begin
            gap       <= {`SSSB_CNT_W{1'b0}};
            sus_alive <= 1'b1;
         end else if (gap == `SSSB_SUS_TICK_MAX) begin
            sus_alive <= 1'b0;
         end else begin
            gap <= gap + 1'b1;
         end
      end
   end
endmodule // sssb_suspend_clock_mon

// ### sssb_sideband.v
// What this block does
// [R01] In SATA mode the interface-indication pin is driven low, in PCIe mode it is released.
// [R02] The host reads that pin through its own pull-up: low means SATA, high means PCIe.
// [R03] In PCIe mode and outside host reset, a wake request from software pulls the wake line low to ask the system to wake.
// [R04] When the host drives the shared wake line itself it signals buffer windows to us.
// [R05] Clock request is an active-low open-drain line, also sampled for L1 substates.
// [R06] The host PCIe reset resets the whole card's function through the card reset output.
// [R07] In SATA mode the device-sleep input makes the block enter and report the device-sleep state.
// [R08] In SATA mode the activity line is driven to show an access in progress.
// [R09] The status indicator is an open-drain low drive for a system LED.
// [R10] The alert output is an open-drain low drive toward the management master.
// [R11] The suspend clock is accepted by edge detection for any duty of 30 to 70 percent.
// [R12] Manufacturing pins are ignored in normal operation.
// [R13] The PCIe link reports four lanes and accepts a two-lane module setting.
// [R14] The optional management bus pins stay released when that bus is unused.
// [R15] The PCIe reference clock comes from the host and is not used in this logic.
// [R16] Every asynchronous sideband input that the logic uses passes a two-flop synchroniser first; the unused smbus and manufacturing inputs do not.
`timescale 1ns/1ps
`include "sssb_consts.vh"
module sssb_sideband (
   mclk,
   rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   irq,
   perst_n,
   devslp,
   clkreq_in,
   clkreq_oe,
   clkreq_out,
   wake_in,
   wake_request_n,
   wake_oe,
   das_in,
   das_out,
   das_oe,
   host_if_indication,
   host_if_oe,
   status_indicator_n,
   status_oe,
   alert_n,
   alert_oe,
   smb_clk_in,
   smb_clk_out,
   smb_clk_oe,
   smb_data_in,
   smb_data_out,
   smb_data_oe,
   suspend_clock,
   manufacturing_clock_pin,
   manufacturing_data_pin,
   card_reset,
   dev_sleep_state
);
   input  wire                      mclk;
   input  wire                      rst;
   input  wire [`SSSB_ADDR_W-1:0]   reg_addr;
   input  wire [7:0]                reg_wdata;
   input  wire                      reg_wr;
   input  wire                      reg_rd;
   output reg  [7:0]                reg_rdata;
   output reg                       irq;
   input  wire                      perst_n;
   input  wire                      devslp;
   input  wire                      clkreq_in;
   output reg                       clkreq_oe;
   output reg                       clkreq_out;
   input  wire                      wake_in;
   output reg                       wake_request_n;
   output reg                       wake_oe;
   input  wire                      das_in;
   output reg                       das_out;
   output reg                       das_oe;
   output reg                       host_if_indication;
   output reg                       host_if_oe;
   output reg                       status_indicator_n;
   output reg                       status_oe;
   output reg                       alert_n;
   output reg                       alert_oe;
   input  wire                      smb_clk_in;
   output reg                       smb_clk_out;
   output reg                       smb_clk_oe;
   input  wire                      smb_data_in;
   output reg                       smb_data_out;
   output reg                       smb_data_oe;
   input  wire                      suspend_clock;
   input  wire                      manufacturing_clock_pin;
   input  wire                      manufacturing_data_pin;
   output reg                       card_reset;
   output reg                       dev_sleep_state;

   reg  [`SSSB_CTRL_W-1:0]  ctrl;
   reg  [`SSSB_EV_W-1:0]    irq_stat;
   reg  [`SSSB_EV_W-1:0]    irq_mask;
   reg  [2:0]               lanes;
   reg                      perst_q;
   reg                      slp_q;
   reg                      wake_q;
   reg                      clkreq_q;
   wire                     perst_s;
   wire                     slp_s;
   wire                     wake_s;
   wire                     clkreq_s;
   wire                     sus_s;
   wire                     das_s;
   wire                     sus_rise;
   wire                     sus_alive;
   reg  [`SSSB_EV_W-1:0]    next_ev;
   reg  [`SSSB_EV_W-1:0]    next_irq_stat;
   reg  [7:0]               next_rdata;
   wire                     sata_mode;
   wire                     wr_ctrl;

   assign sata_mode = ctrl[`SSSB_CTRL_SATA];
   assign wr_ctrl   = reg_wr && (reg_addr == `SSSB_REG_CTRL);

   // [R16] input synchronisers
   sssb_sync #(.RST_VAL(1'b0)) u_perst (
      .mclk (mclk),
      .rst  (rst),
      .din  (perst_n),
      .dout (perst_s)
   );
   sssb_sync #(.RST_VAL(1'b0)) u_slp (
      .mclk (mclk),
      .rst  (rst),
      .din  (devslp),
      .dout (slp_s)
   );
   sssb_sync #(.RST_VAL(1'b1)) u_wake (
      .mclk (mclk),
      .rst  (rst),
      .din  (wake_in),
      .dout (wake_s)
   );
   sssb_sync #(.RST_VAL(1'b1)) u_clkreq (
      .mclk (mclk),
      .rst  (rst),
      .din  (clkreq_in),
      .dout (clkreq_s)
   );
   sssb_sync #(.RST_VAL(1'b0)) u_sus (
      .mclk (mclk),
      .rst  (rst),
      .din  (suspend_clock),
      .dout (sus_s)
   );
   // activity line idles high through the host pull-up
   sssb_sync #(.RST_VAL(1'b1)) u_das (
      .mclk (mclk),
      .rst  (rst),
      .din  (das_in),
      .dout (das_s)
   );

   // [R11] suspend clock edge monitor
   sssb_suspend_clock_mon u_sus_mon (
      .mclk      (mclk),
      .rst       (rst),
      .sus_sync  (sus_s),
      .sus_rise  (sus_rise),
      .sus_alive (sus_alive)
   );

   always @* begin
      next_ev = `SSSB_EV_ZERO;
      next_ev[`SSSB_EV_PERST_ON]  = perst_q & ~perst_s;
      next_ev[`SSSB_EV_PERST_OFF] = ~perst_q & perst_s;
      next_ev[`SSSB_EV_SLP_ON]    = ~slp_q & slp_s & sata_mode;
      next_ev[`SSSB_EV_SLP_OFF]   = slp_q & ~slp_s & sata_mode;
      // [R04] host-driven wake edge while we are not driving it
      next_ev[`SSSB_EV_OBFF]      = wake_q & ~wake_s & ~ctrl[`SSSB_CTRL_WAKE];
      // [R05] clock request assertion seen on the shared line
      next_ev[`SSSB_EV_CLKREQ]    = clkreq_q & ~clkreq_s;
      // set wins over write-one-to-clear
      next_irq_stat = irq_stat;
      if (reg_wr && (reg_addr == `SSSB_REG_IRQ_STAT)) begin
         next_irq_stat = irq_stat & ~reg_wdata[`SSSB_EV_W-1:0];
      end
      next_irq_stat = next_irq_stat | next_ev;
   end

   always @* begin
      next_rdata = 8'h00;
      case (reg_addr)
         `SSSB_REG_CTRL:     next_rdata = ctrl;
         `SSSB_REG_STATUS:   next_rdata = {2'b00, sus_alive, dev_sleep_state,
                                           ~clkreq_s, ~wake_s, das_s, card_reset};
         `SSSB_REG_IRQ_STAT: next_rdata = {2'b00, irq_stat};
         `SSSB_REG_IRQ_MASK: next_rdata = {2'b00, irq_mask};
         `SSSB_REG_LANES:    next_rdata = {5'b00000, lanes};
         default:            next_rdata = 8'h00;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl      <= `SSSB_CTRL_RESET;
         irq_stat  <= `SSSB_EV_ZERO;
         irq_mask  <= `SSSB_EV_ZERO;
         lanes     <= `SSSB_MAX_LANES;
         reg_rdata <= 8'h00;
         perst_q   <= 1'b0;
         slp_q     <= 1'b0;
         wake_q    <= 1'b1;
         clkreq_q  <= 1'b1;
      end else begin
         perst_q  <= perst_s;
         slp_q    <= slp_s;
         wake_q   <= wake_s;
         clkreq_q <= clkreq_s;
         irq_stat <= next_irq_stat;
         if (wr_ctrl) begin
            ctrl <= reg_wdata;
         end
         if (reg_wr && (reg_addr == `SSSB_REG_IRQ_MASK)) begin
            irq_mask <= reg_wdata[`SSSB_EV_W-1:0];
         end
         // [R13] four or two lanes only
         if (reg_wr && (reg_addr == `SSSB_REG_LANES)) begin
            if (reg_wdata[2:0] == `SSSB_MIN_LANES) begin
               lanes <= `SSSB_MIN_LANES;
            end else begin
               lanes <= `SSSB_MAX_LANES;
            end
         end
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   // pin drivers; open-drain pins drive low only when enabled
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq                <= 1'b0;
         card_reset         <= 1'b1;
         dev_sleep_state    <= 1'b0;
         host_if_indication <= 1'b0;
         host_if_oe         <= 1'b0;
         wake_request_n     <= 1'b0;
         wake_oe            <= 1'b0;
         clkreq_out         <= 1'b0;
         clkreq_oe          <= 1'b0;
         das_out            <= 1'b0;
         das_oe             <= 1'b0;
         status_indicator_n <= 1'b0;
         status_oe          <= 1'b0;
         alert_n            <= 1'b0;
         alert_oe           <= 1'b0;
         smb_clk_out        <= 1'b0;
         smb_clk_oe         <= 1'b0;
         smb_data_out       <= 1'b0;
         smb_data_oe        <= 1'b0;
      end else begin
         irq <= |(next_irq_stat & irq_mask);
         // [R06] host reset holds the card in reset
         card_reset <= ~perst_s;
         // [R07] device sleep state follows the input in SATA mode
         dev_sleep_state <= slp_s & sata_mode;
         // [R01] ground for SATA, released for PCIe
         host_if_oe <= sata_mode;
         // [R03] wake request pulls the line low, not while in reset
         wake_oe <= ctrl[`SSSB_CTRL_WAKE] & ~sata_mode & perst_s;
         // [R05] clock request low drive
         clkreq_oe <= ctrl[`SSSB_CTRL_CLKREQ] & ~sata_mode;
         // [R08] activity drive in SATA mode only
         das_oe  <= sata_mode;
         das_out <= ctrl[`SSSB_CTRL_ACT] & ~dev_sleep_state;
         // [R09] status indicator low drive
         status_oe <= ctrl[`SSSB_CTRL_LED];
         // [R10] alert low drive
         alert_oe <= ctrl[`SSSB_CTRL_ALERT];
         // [R14] management bus never driven here; only released
         smb_clk_oe  <= 1'b0;
         smb_data_oe <= 1'b0;
         // open-drain data levels stay low; only the enables move
         clkreq_out         <= 1'b0;
         wake_request_n     <= 1'b0;
         host_if_indication <= 1'b0;
         status_indicator_n <= 1'b0;
         alert_n            <= 1'b0;
         smb_clk_out        <= 1'b0;
         smb_data_out       <= 1'b0;
      end
   end
   // [R12] manufacturing pins, smbus inputs and suspend edge pulse are unused by design
endmodule // sssb_sideband

// ### sssb_host_model.sv
`timescale 1ns/1ps
module sssb_host_model (
   input  wire logic wake_oe,
   input  wire logic clkreq_oe,
   input  wire logic host_if_oe,
   input  wire logic das_oe,
   input  wire logic das_out,
   input  wire logic smb_clk_oe,
   input  wire logic smb_data_oe,
   input  wire logic host_wake,
   input  wire logic sus_run,
   input  wire logic sus_wide,
   output logic      wake_line,
   output logic      clkreq_line,
   output logic      host_if_indication_line,
   output logic      das_line,
   output logic      smb_clk_line,
   output logic      smb_data_line,
   output logic      suspend_clock
);
   parameter int HI_NS = 9155;
   parameter int LO_NS = 21363;
   assign wake_line = !(wake_oe || host_wake);
   assign clkreq_line = !clkreq_oe;
   assign host_if_indication_line = !host_if_oe;
   assign das_line = das_oe ? das_out : 1'b1;
   assign smb_clk_line = !smb_clk_oe;
   assign smb_data_line = !smb_data_oe;
   // reference clock not modelled; the block has no input for it
   // 30 or 70 percent duty, still and low when off
   initial begin
      suspend_clock = 1'b0;
      forever begin
         wait (sus_run);
         suspend_clock = 1'b1;
         #(sus_wide ? LO_NS : HI_NS);
         suspend_clock = 1'b0;
         #(sus_wide ? HI_NS : LO_NS);
      end
   end
endmodule // sssb_host_model

// ### sssb_sideband_sva.sv
`timescale 1ns/1ps
`include "sssb_consts.vh"
module sssb_sva (
   input wire logic                     mclk,
   input wire logic                     rst,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic                     irq,
   input wire logic                     perst_n,
   input wire logic                     card_reset,
   input wire logic [`SSSB_ADDR_W-1:0]  reg_addr,
   input wire logic [7:0]               reg_wdata,
   input wire logic [7:0]               reg_rdata,
   input wire logic                     status_oe,
   input wire logic                     alert_oe,
   input wire logic                     host_if_oe,
   input wire logic                     wake_oe,
   input wire logic                     clkreq_out,
   input wire logic                     wake_request_n,
   input wire logic                     status_indicator_n,
   input wire logic                     alert_n,
   input wire logic                     host_if_indication,
   input wire logic                     smb_clk_oe,
   input wire logic                     smb_data_oe,
   input wire logic                     dev_sleep_state
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire ctl_wr = reg_wr && reg_addr == `SSSB_REG_CTRL && !card_reset;
   wire msk_wr = reg_wr && reg_addr == `SSSB_REG_IRQ_MASK;
   od_low_a:
   assert property (!(clkreq_out | wake_request_n | status_indicator_n | alert_n
      | host_if_indication)) else $error("open-drain data not low");
   smb_idle_a:
   assert property (!smb_clk_oe && !smb_data_oe) else $error("unused bus driven");
   led_drive_a:
   assert property (ctl_wr ##1 !card_reset |=> status_oe ==
      $past(reg_wdata[`SSSB_CTRL_LED], 2)) else $error("indicator drive wrong");
   alert_drive_a:
   assert property (ctl_wr ##1 !card_reset |=> alert_oe ==
      $past(reg_wdata[`SSSB_CTRL_ALERT], 2)) else $error("alert drive wrong");
   host_if_a:
   assert property (ctl_wr ##1 !card_reset |=> host_if_oe ==
      $past(reg_wdata[`SSSB_CTRL_SATA], 2)) else $error("indication drive wrong");
   perst_hold_a:
   assert property (!perst_n [*3] |=> card_reset) else $error("card reset missing");
   perst_free_a:
   assert property (perst_n [*4] |=> !card_reset) else $error("card reset stuck");
   wake_block_a:
   assert property (!perst_n [*4] |=> !wake_oe) else $error("wake during reset");
   mask_off_a:
   assert property (msk_wr && reg_wdata == 8'h00 ##1 !msk_wr |=> !irq)
      else $error("masked irq high");
   rd_idle_a:
   assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
   cover property (irq);
   cover property ($fell(card_reset));
   cover property (dev_sleep_state);
   cover property (wake_oe);
endmodule // sssb_sva
bind sssb_sideband sssb_sva u_sva (.*);

// ### test_ssd_socket_sideband_signals.sv
`timescale 1ns/1ps
`include "sssb_consts.vh"
module test_ssd_socket_sideband_signals;
   logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, perst_n = 1'b0;
   logic devslp = 1'b0, host_wake = 1'b0, sus_run = 1'b0, sus_wide = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, rv;
   wire [7:0] reg_rdata;
   wire irq, clkreq_oe, clkreq_out, wake_request_n, wake_oe, das_out, das_oe;
   wire host_if_indication, host_if_oe, status_indicator_n, status_oe, alert_n, alert_oe;
   wire smb_clk_out, smb_clk_oe, smb_data_out, smb_data_oe, card_reset, dev_sleep_state;
   wire wake_line, clkreq_line, host_if_indication_line, das_line, smb_clk_line, smb_data_line;
   wire suspend_clock;
   int fail_count = 0, compares = 0, i;
   sssb_host_model u_host (.*);
   sssb_sideband u_dut (.*, .clkreq_in(clkreq_line), .wake_in(wake_line), .das_in(das_line),
      .smb_clk_in(smb_clk_line), .smb_data_in(smb_data_line),
      .manufacturing_clock_pin(1'bz), // left open by the platform
      .manufacturing_data_pin(1'bz)); // left open by the platform
   always #10 mclk = ~mclk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask
   task automatic wait_irq;
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      if (irq !== 1'b1) begin
         fail_count++;
         test_done;
      end
   endtask
   task automatic t_perst;
      wr(`SSSB_REG_IRQ_MASK, 8'h3F);
      @(posedge mclk);
      perst_n <= 1'b1;
      wait_irq;
      chk(card_reset, 1'b0);
      rd(`SSSB_REG_IRQ_STAT);
      chk(rv, 8'h02);
      wr(`SSSB_REG_IRQ_STAT, 8'h02);
      rd(`SSSB_REG_IRQ_STAT);
      chk(rv, 8'h00);
      chk(irq, 1'b0);
      $display("perst release done");
   endtask
   task automatic t_regs;
      rd(`SSSB_REG_LANES);
      chk(rv, 8'h04);
      wr(`SSSB_REG_LANES, 8'h02);
      rd(`SSSB_REG_LANES);
      chk(rv, 8'h02);
      wr(`SSSB_REG_LANES, 8'h03);
      rd(`SSSB_REG_LANES);
      chk(rv, 8'h04);
      rd(4'hF);
      chk(rv, 8'h00);
      $display("registers done");
   endtask
   task automatic t_pins;
      for (i = 0; i < 5; i++) begin
         wr(`SSSB_REG_CTRL, 8'h01 << i);
         cyc(2);
         chk({alert_oe, status_oe, clkreq_oe, wake_oe, host_if_oe}, 8'h01 << i);
         chk(host_if_indication_line, i != 0);
      end
      wr(`SSSB_REG_CTRL, 8'h21);
      cyc(2);
      chk(das_oe, 1'b1);
      chk(das_line, 1'b1);
      wr(`SSSB_REG_CTRL, 8'h01);
      cyc(2);
      chk(das_line, 1'b0);
      wr(`SSSB_REG_CTRL, 8'h20);
      cyc(2);
      chk(das_oe, 1'b0);
      $display("pin drives done");
   endtask
   task automatic t_events;
      wr(`SSSB_REG_IRQ_STAT, 8'h3F);
      cyc(2);
      chk(irq, 1'b0);
      host_wake <= 1'b1;
      wait_irq;
      host_wake <= 1'b0;
      rd(`SSSB_REG_IRQ_STAT);
      chk(rv & 8'h10, 8'h10);
      wr(`SSSB_REG_CTRL, 8'h01);
      devslp <= 1'b1;
      cyc(5);
      chk(dev_sleep_state, 1'b1);
      rd(`SSSB_REG_STATUS);
      chk(rv & 8'h10, 8'h10);
      devslp <= 1'b0;
      cyc(5);
      chk(dev_sleep_state, 1'b0);
      rd(`SSSB_REG_IRQ_STAT);
      chk(rv & 8'h0C, 8'h0C);
      wr(`SSSB_REG_IRQ_MASK, 8'h00);
      cyc(3);
      chk(irq, 1'b0);
      $display("events done");
   endtask
   task automatic t_sus;
      for (i = 0; i < 2; i++) begin
         sus_wide <= (i == 1);
         sus_run <= 1'b1;
         cyc(3200);
         rd(`SSSB_REG_STATUS);
         chk(rv & 8'h20, 8'h20);
         sus_run <= 1'b0;
         cyc(3200);
         rd(`SSSB_REG_STATUS);
         chk(rv & 8'h20, 8'h00);
      end
      wr(`SSSB_REG_CTRL, 8'h02);
      cyc(2);
      chk(wake_oe, 1'b1);
      rd(`SSSB_REG_STATUS);
      chk(rv, 8'h06);
      perst_n <= 1'b0;
      cyc(5);
      chk(card_reset, 1'b1);
      chk(wake_oe, 1'b0);
      $display("suspend clock done");
   endtask
   task automatic test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      test_done;
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_perst;
      t_regs;
      t_pins;
      t_events;
      t_sus;
      test_done;
   end
endmodule // test_ssd_socket_sideband_signals
